//--- ripple_checker.sv
// Concurrent checks on the ports of the ripple count parameter logic
`timescale 1ns/1ps

module ripple_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire ripple_pkg::bus_req_t bus_req,
	input wire logic [15:0] bp_gain,
	input wire logic [7:0] bp_damping,
	input wire logic [23:0] conductance_eff,
	input wire logic [31:0] backemf_eff,
	input wire logic ripple_pulse_out,
	input wire logic fault_out_n
);
	import ripple_pkg::*;

	// ----------------------------------------------------------------
	// Shadow state
	// ----------------------------------------------------------------
	logic [15:0] ctrl_q; // Control word as last written
	logic [31:0] motor_q; // Motor word as last written
	logic [15:0] filt_q; // Filter word as last written
	logic [11:0] high_q; // Cycles the ripple pulse has stood high
	// Multipliers straight from the scale tables, not from shifts
	wire logic [13:0] cond_mul = motor_q[9] ? (motor_q[8] ? 14'h2000 : 14'h0400)
		: (motor_q[8] ? 14'h0040 : 14'h0002);
	wire logic [17:0] emf_mul = motor_q[25] ? (motor_q[24] ? 18'h30000 : 18'h18000)
		: (motor_q[24] ? 18'h03000 : 18'h01800);
	wire logic [15:0] gain_exp = filt_q[9] ? (filt_q[8] ? 16'h0010 : 16'h0008)
		: (filt_q[8] ? 16'h0004 : 16'h0002);
	wire logic [23:0] cond_exp = 24'(motor_q[7:0]) * 24'(cond_mul); // Expected conductance
	wire logic [31:0] emf_exp = 32'(motor_q[23:16]) * 32'(emf_mul); // Expected back-EMF

	// Follow writes; the design applies them at the same edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= CTRL_RST;
			motor_q <= MOTOR_RST;
			filt_q <= FILT_RST;
		end else if (bus_req.wr) begin
			ctrl_q <= (bus_req.addr == REG_CTRL) ? bus_req.wdata[15:0] : ctrl_q;
			motor_q <= (bus_req.addr == REG_MOTOR) ? bus_req.wdata : motor_q;
			filt_q <= (bus_req.addr == REG_FILT) ? bus_req.wdata[15:0] : filt_q;
		end
	end

	// Length of the current pulse, zero while low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			high_q <= 12'h000;
		end else begin
			high_q <= ripple_pulse_out ? high_q + 12'h001 : 12'h000;
		end
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Start of one output pulse
	sequence pulse_start_s;
		$rose(ripple_pulse_out);
	endsequence

	cond_scale_a: assert property (conductance_eff == cond_exp)
		else $error("conductance product does not match its scale code");
	emf_scale_a: assert property (backemf_eff == emf_exp)
		else $error("back-EMF product does not match its scale code");
	gain_decode_a: assert property (bp_gain == gain_exp)
		else $error("band-pass gain does not match its selector");
	damping_field_a: assert property (bp_damping == filt_q[7:0])
		else $error("band-pass damping differs from the written value");
	pulse_len_a: assert property ($fell(ripple_pulse_out) |-> high_q == 12'(PULSE_CYC))
		else $error("ripple pulse width wrong");
	enable_gate_a: assert property (pulse_start_s |-> $past(ctrl_q[CTRL_EN]))
		else $error("ripple pulse started while counting disabled");
	corr_off_a: assert property (pulse_start_s |-> !$past(ctrl_q[CTRL_CORRECTOR_DISABLE]))
		else $error("ripple pulse started with corrector disabled");
	fault_quiet_a: assert property ((!ctrl_q[3] && !$past(ctrl_q[3])) |-> fault_out_n)
		else $error("fault driven low in a quiet report mode");
endmodule : ripple_checker

//--- ripple_count_param_logic.sv
// Ripple count parameter, threshold and error corrector logic
`timescale 1ns/1ps

module ripple_count_param_logic #(
	parameter int CW = 16, // Ripple counter width
	parameter int PW = 16 // Interval estimate width
) (
	input wire logic clk,
	input wire logic resetn,
	input wire ripple_pkg::bus_req_t bus_req, // Register port request
	output logic [31:0] rdata, // Read data, cycle after read strobe
	input wire logic bp_ripple_raw, // Filtered ripple detect from front end
	input wire logic [11:0] vout_diff, // Output differential sample
	input wire logic [7:0] pwm_duty, // Bridge duty, 255 is full on
	input wire logic [11:0] vm_sample, // Supply voltage sample
	output logic [11:0] vout_est, // Motor voltage estimate, averaged or duty times supply
	output logic [15:0] bp_gain, // Decoded band-pass input gain
	output logic [15:0] bp_centre, // Band-pass centre as interval, cycles
	output logic [7:0] bp_damping, // Band-pass quality setting
	output logic [23:0] conductance_eff, // Scaled conductance product
	output logic [31:0] backemf_eff, // Scaled back-EMF product
	output logic [CW-1:0] count_lowpass, // Mechanically smoothed count
	output logic ripple_pulse_out, // Ripple pulse, active high
	output logic fault_out_n // Fault request, active low
);
	import ripple_pkg::*;

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	// Conductance multiplier as a shift amount
	function automatic logic [3:0] cond_shift(input logic [1:0] s);
		unique case (s)
			2'b00: cond_shift = 4'h1;
			2'b01: cond_shift = 4'h6;
			2'b10: cond_shift = 4'ha;
			2'b11: cond_shift = 4'hd;
		endcase
	endfunction : cond_shift

	// Back-EMF multiplier as a shift of 24
	function automatic logic [3:0] emf_shift(input logic [1:0] s);
		unique case (s)
			2'b00: emf_shift = 4'h8;
			2'b01: emf_shift = 4'h9;
			2'b10: emf_shift = 4'hc;
			2'b11: emf_shift = 4'hd;
		endcase
	endfunction : emf_shift

	// Threshold multiplier as a shift
	function automatic logic [3:0] thr_shift(input logic [1:0] s);
		unique case (s)
			2'b00: thr_shift = 4'h1;
			2'b01: thr_shift = 4'h3;
			2'b10: thr_shift = 4'h4;
			2'b11: thr_shift = 4'h6;
		endcase
	endfunction : thr_shift

	// Fraction of the interval: code n gives (n+1)/8 of it
	function automatic logic [PW-1:0] frac(input logic [PW-1:0] p, input logic [1:0] c);
		logic [PW+1:0] t;
		t = {2'b00, p >> 3} * ({{PW{1'b0}}, c} + 1'b1);
		frac = t[PW-1:0];
	endfunction : frac

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	ctrl_t ctrl_q; // Control fields
	logic [31:0] motor_q; // [7:0] cond, [9:8] cond scale, [23:16] emf, [25:24] emf scale
	logic [15:0] filt_q; // [7:0] damping, [9:8] gain, [15:12] lowpass shift
	logic [9:0] thr_q; // [7:0] threshold, [9:8] scale
	logic [CW-1:0] thr_count_q; // Threshold ripple count
	logic done_q; // Count done flag
	logic [CW-1:0] count_q; // Ripple counter
	logic [31:0] rdata_q; // Read data register

	// Bus decode
	wire wr_ctrl = bus_req.wr && (bus_req.addr == REG_CTRL);
	wire wr_motor = bus_req.wr && (bus_req.addr == REG_MOTOR);
	wire wr_filt = bus_req.wr && (bus_req.addr == REG_FILT);
	wire wr_thr = bus_req.wr && (bus_req.addr == REG_THR);
	wire count_clear = wr_ctrl && bus_req.wdata[CTRL_CLR];

	// Register writes; clear bit itself is not stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Same layout as a control write, so the reset word lines up
			ctrl_q <= {CTRL_RST[13:8], CTRL_RST[6:2], CTRL_RST[CTRL_EN]};
			motor_q <= MOTOR_RST;
			filt_q <= FILT_RST;
			thr_q <= THR_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {bus_req.wdata[13:8], bus_req.wdata[6:2], bus_req.wdata[CTRL_EN]};
			end
			if (wr_motor) begin
				motor_q <= bus_req.wdata;
			end
			if (wr_filt) begin
				filt_q <= bus_req.wdata[15:0];
			end
			if (wr_thr) begin
				thr_q <= bus_req.wdata[9:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Parameter products
	// ----------------------------------------------------------------
	// Host keeps the conductance byte within 255 by construction of the field
	assign conductance_eff = {16'h0000, motor_q[7:0]} << cond_shift(motor_q[9:8]);
	assign backemf_eff = ({24'h000000, motor_q[23:16]} * 32'd24) << emf_shift(motor_q[25:24]);
	assign bp_gain = 16'h0002 << filt_q[9:8];
	assign bp_damping = filt_q[7:0];

	// Threshold count; depends only on threshold fields, never on detection
	wire [CW+7:0] thr_prod = {{CW{1'b0}}, thr_q[7:0]} << thr_shift(thr_q[9:8]);
	wire [CW-1:0] thr_sat = (|thr_prod[CW+7:CW]) ? {CW{1'b1}} : thr_prod[CW-1:0];

	// ----------------------------------------------------------------
	// Ripple input synchroniser and edge detect
	// ----------------------------------------------------------------
	logic rip_s1_q, rip_s2_q, rip_s3_q; // Two-flop sync plus edge stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rip_s1_q <= 1'b0;
			rip_s2_q <= 1'b0;
			rip_s3_q <= 1'b0;
		end else begin
			rip_s1_q <= bp_ripple_raw;
			rip_s2_q <= rip_s1_q;
			rip_s3_q <= rip_s2_q;
		end
	end
	wire bp_edge = rip_s2_q && !rip_s3_q; // One event per filtered ripple

	// ----------------------------------------------------------------
	// Error corrector: interval tracking, blanking and insertion
	// ----------------------------------------------------------------
	logic [PW-1:0] period_q; // Running ripple interval estimate
	logic [PW-1:0] since_q; // Cycles since last accepted or inserted ripple
	logic [3:0] ins_run_q; // Consecutive inserted ripples
	logic muted_q; // Corrector output suppressed
	logic armed_q; // A ripple seen since enable

	wire ec_on = !ctrl_q.ec_dis;
	// No blanking before the first ripple after enable: nothing to blank from
	wire in_blank = armed_q && (since_q < frac(period_q, ctrl_q.blank_win));
	// Missed window closes at interval plus its fraction
	wire [PW:0] miss_lim = {1'b0, period_q} + {1'b0, frac(period_q, ctrl_q.miss_win)};
	wire miss_hit = ec_on && ({1'b0, since_q} >= miss_lim);
	wire bp_accept = bp_edge && !(ec_on && in_blank);
	wire inserted = miss_hit && !bp_accept;
	wire ripple_evt = ctrl_q.enable && (bp_accept || inserted) && !muted_q;
	wire [PW-1:0] period_avg = period_q - (period_q >> 3) + (since_q >> 3);

	// Track interval and the insertion run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			period_q <= PW'(PERIOD_INIT);
			since_q <= '0;
			ins_run_q <= 4'h0;
			muted_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (!ctrl_q.enable || ctrl_q.ec_dis) begin
			since_q <= '0;
			ins_run_q <= 4'h0;
			muted_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			since_q <= (bp_accept || inserted) ? '0 : since_q + 1'b1;
			// First accepted or inserted ripple gives a reference point
			armed_q <= armed_q || bp_accept || inserted;
			if (bp_accept) begin
				// Time from enable to the first ripple is no ripple interval
				if (armed_q) begin
					period_q <= period_avg;
				end
				ins_run_q <= 4'h0;
				muted_q <= 1'b0;
			end else if (inserted && ins_run_q != 4'(MISS_RUN)) begin
				ins_run_q <= ins_run_q + 1'b1;
			end
			// With pulse disable set, twelve inserted with no filter ripple silences output
			if (ctrl_q.corrector_pulse_disable && inserted && ins_run_q == 4'(MISS_RUN - 1)) begin
				muted_q <= 1'b1;
			end
			if (!ctrl_q.corrector_pulse_disable) begin
				muted_q <= 1'b0;
			end
		end
	end
	// Estimate width is a parameter; the port stays sixteen bits
	assign bp_centre = 16'(period_q);

	// ----------------------------------------------------------------
	// Pulse output, 50 us per counted ripple
	// ----------------------------------------------------------------
	localparam int PCW = $clog2(PULSE_CYC + 1);
	logic [PCW-1:0] pulse_cnt_q; // Remaining pulse cycles
	logic pulse_q; // Pulse output register
	// Corrector disabled: no pulses at all on the output
	wire pulse_start = ripple_evt && ec_on;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pulse_cnt_q <= '0;
			pulse_q <= 1'b0;
		end else if (pulse_start) begin
			pulse_cnt_q <= PCW'(PULSE_CYC - 1);
			pulse_q <= 1'b1;
		end else if (pulse_cnt_q != '0) begin
			pulse_cnt_q <= pulse_cnt_q - 1'b1;
		end else begin
			pulse_q <= 1'b0;
		end
	end
	assign ripple_pulse_out = pulse_q;

	// ----------------------------------------------------------------
	// Ripple counter, threshold count and done flag
	// ----------------------------------------------------------------
	wire at_max = &count_q;
	wire wrap_mode = ctrl_q.rep_mode[0];
	wire over_thr = thr_count_q > thr_sat;
	wire [CW:0] thr_next = {1'b0, thr_count_q} + 1'b1; // Count after this increment
	wire thr_cross = pulse_start && !(&thr_count_q) && (thr_next > {1'b0, thr_sat});
	// Stored level is ignored in the clearing cycle, since the count is zeroed there
	wire done_set = thr_cross || (over_thr && !count_clear);

	// Counter steps with each pulse start, holding at max in hold modes; threshold plays no part
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
			thr_count_q <= '0;
			done_q <= 1'b0;
		end else begin
			if (count_clear) begin
				count_q <= '0;
			end else if (pulse_start && !(at_max && !wrap_mode)) begin
				count_q <= count_q + 1'b1;
			end
			if (count_clear) begin
				thr_count_q <= '0;
			end else if (pulse_start && !(&thr_count_q)) begin
				thr_count_q <= thr_count_q + 1'b1;
			end
			// A crossing ripple wins over a clear in the same cycle
			if (done_set) begin
				done_q <= 1'b1;
			end else if (count_clear) begin
				done_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fault reporting
	// ----------------------------------------------------------------
	logic [PCW-1:0] fpulse_q; // Fault pulse timer for wrap report
	logic fault_n_q; // Fault output register
	wire wrap_evt = pulse_start && at_max && wrap_mode;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fpulse_q <= '0;
			fault_n_q <= 1'b1;
		end else begin
			if (wrap_evt && ctrl_q.rep_mode == REP_WRAP_FLT) begin
				fpulse_q <= PCW'(PULSE_CYC);
			end else if (fpulse_q != '0) begin
				fpulse_q <= fpulse_q - 1'b1;
			end
			unique case (rep_mode_t'(ctrl_q.rep_mode))
				REP_HOLD, REP_WRAP: fault_n_q <= 1'b1;
				REP_HOLD_FLT: fault_n_q <= !done_q;
				REP_WRAP_FLT: fault_n_q <= (fpulse_q == '0);
			endcase
		end
	end
	assign fault_out_n = fault_n_q;

	// ----------------------------------------------------------------
	// Mechanical low-pass on the counter output
	// ----------------------------------------------------------------
	logic [CW+15:0] lp_acc_q; // Fixed-point accumulator
	wire [3:0] lp_k = filt_q[15:12]; // Larger shift, slower response
	wire [CW+15:0] lp_in = {count_q, 16'h0000};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lp_acc_q <= '0;
		end else if (count_clear) begin
			lp_acc_q <= '0;
		end else begin
			lp_acc_q <= lp_acc_q - (lp_acc_q >> lp_k) + (lp_in >> lp_k);
		end
	end
	assign count_lowpass = lp_acc_q[CW+15:16];

	// ----------------------------------------------------------------
	// Output voltage sensing
	// ----------------------------------------------------------------
	logic [11:0] vflt_q; // Analog path average
	logic [11:0] vest_q; // Selected estimate register
	wire [3:0] of_k = {2'b00, ctrl_q.output_filter_cutoff} + 4'h2; // Cutoff as shift
	wire [19:0] dig_prod = vm_sample * pwm_duty; // Duty times supply
	wire [13:0] vflt_ext = {2'b00, vflt_q};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vflt_q <= 12'h000;
			vest_q <= 12'h000;
		end else begin
			vflt_q <= 12'(vflt_ext - (vflt_ext >> of_k) + ({2'b00, vout_diff} >> of_k));
			vest_q <= ctrl_q.voltage_sense_sel ? dig_prod[19:8] : vflt_q;
		end
	end
	assign vout_est = vest_q;

	// ----------------------------------------------------------------
	// Read port, data in the cycle after the strobe
	// ----------------------------------------------------------------
	logic [31:0] rmux; // Selected read word
	always_comb begin
		unique case (bus_req.addr)
			// Gaps at the clear bit and bit 7 read as zero
			REG_CTRL: rmux = {18'h0, ctrl_q[11:6], 1'b0, ctrl_q[5:1], 1'b0, ctrl_q[0]};
			REG_MOTOR: rmux = motor_q;
			REG_FILT: rmux = {16'h0000, filt_q};
			REG_THR: rmux = {22'h0, thr_q};
			REG_COUNT: rmux = 32'(count_q);
			REG_STATUS: rmux = {31'h0, done_q};
			REG_THRCNT: rmux = 32'(thr_count_q);
			default: rmux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= bus_req.rd ? rmux : 32'h0000_0000;
		end
	end
	assign rdata = rdata_q;

endmodule : ripple_count_param_logic

//--- ripple_pkg.sv
// Package: constants, types and register map for the ripple count logic
package ripple_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000; // System clock rate
	localparam int PULSE_US = 50; // Ripple pulse width in microseconds
	localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1000000)); // Cycles per pulse
	localparam int MISS_RUN = 12; // Inserted pulses in a row before mute
	localparam int PERIOD_INIT = 4000; // Starting ripple interval estimate, cycles

	// ----------------------------------------------------------------
	// Register offsets (word index on the plain port)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0; // Enable, clear, modes, corrector bits
	localparam logic [3:0] REG_MOTOR = 4'h1; // Conductance, back-EMF and scales
	localparam logic [3:0] REG_FILT = 4'h2; // Band-pass and low-pass settings
	localparam logic [3:0] REG_THR = 4'h3; // Threshold value and scale
	localparam logic [3:0] REG_COUNT = 4'h4; // Ripple counter, read only
	localparam logic [3:0] REG_STATUS = 4'h5; // Done flag in bit 0, other bits read zero
	localparam logic [3:0] REG_THRCNT = 4'h6; // Threshold count, read only

	// ----------------------------------------------------------------
	// Control field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EN = 0; // Ripple count enable
	localparam int CTRL_CLR = 1; // Count clear, self clearing
	localparam int CTRL_REP = 2; // Report mode, two bits
	localparam int CTRL_VSNS = 4; // Voltage sense select
	localparam int CTRL_CORRECTOR_DISABLE = 5; // Corrector disable
	localparam int CTRL_EC_PD = 6; // Corrector pulse disable
	localparam int CTRL_BLANK = 8; // Extra ripple blank window, two bits
	localparam int CTRL_MISS = 10; // Missed ripple window, two bits
	localparam int CTRL_OFLT = 12; // Output filter cutoff, two bits
	localparam logic [15:0] CTRL_RST = 16'h0000; // Control after reset
	localparam logic [31:0] MOTOR_RST = 32'h0000_0000; // Motor params after reset
	localparam logic [15:0] FILT_RST = 16'h0000; // Filter params after reset
	localparam logic [9:0] THR_RST = 10'h000; // Threshold after reset

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] output_filter_cutoff; // Output filter cutoff
		logic [1:0] miss_win; // Missed ripple window
		logic [1:0] blank_win; // Extra ripple blank window
		logic corrector_pulse_disable; // Corrector pulse disable
		logic ec_dis; // Corrector disable
		logic voltage_sense_sel; // Voltage sense select
		logic [1:0] rep_mode; // Report mode
		logic enable; // Ripple count enable
	} ctrl_t;

	typedef struct packed {
		logic [3:0] addr; // Register index
		logic [31:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} bus_req_t;

	typedef enum logic [1:0] {
		REP_HOLD = 2'b00, // Hold at max, no fault
		REP_WRAP = 2'b01, // Wrap, no fault
		REP_HOLD_FLT = 2'b10, // Hold, fault over threshold
		REP_WRAP_FLT = 2'b11 // Wrap, fault pulse at max
	} rep_mode_t;

endpackage : ripple_pkg

//--- ripple_source.sv
// Ripple source standing in for the current-sense front end
`timescale 1ns/1ps

module ripple_source (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fire,
	output logic bp_ripple_raw
);
	logic [4:0] left_q; // Cycles of ripple level still to show

	// Comparator output idles low; one request gives one rising edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			left_q <= 5'h00;
		end else if (fire) begin
			left_q <= 5'h10;
		end else if (left_q != 5'h00) begin
			left_q <= left_q - 5'h01;
		end
	end
	assign bp_ripple_raw = (left_q != 5'h00);
endmodule : ripple_source

//--- tb_top.sv
// Self-checking testbench for the ripple count parameter logic
`timescale 1ns/1ps

module tb_top;
	import ripple_pkg::*;
	logic clk; // 40 MHz clock
	logic resetn; // Active-low reset
	logic fire; // Ripple request to the source
	bus_req_t bus_req; // Register port request
	logic [31:0] rdata; // Read data
	logic bp_ripple_raw; // Ripple level from the source
	logic [11:0] vout_diff; // Output differential sample
	logic [7:0] pwm_duty; // Bridge duty
	logic [11:0] vm_sample; // Supply sample
	logic [11:0] vout_est; // Voltage estimate
	logic [15:0] bp_gain; // Band-pass gain
	logic [15:0] bp_centre; // Interval estimate
	logic [7:0] bp_damping; // Damping field
	logic [23:0] conductance_eff; // Conductance product
	logic [31:0] backemf_eff; // Back-EMF product
	logic [15:0] count_lowpass; // Smoothed count
	logic ripple_pulse_out; // Ripple pulse
	logic fault_out_n; // Fault, active low
	int num_errors; // Mismatches
	int num_checks; // Comparisons
	int rises; // Pulse starts seen

	ripple_count_param_logic ripple_count_param_logic_inst (
		.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
		.bp_ripple_raw(bp_ripple_raw), .vout_diff(vout_diff), .pwm_duty(pwm_duty),
		.vm_sample(vm_sample), .vout_est(vout_est), .bp_gain(bp_gain), .bp_centre(bp_centre),
		.bp_damping(bp_damping), .conductance_eff(conductance_eff), .backemf_eff(backemf_eff),
		.count_lowpass(count_lowpass), .ripple_pulse_out(ripple_pulse_out),
		.fault_out_n(fault_out_n));
	ripple_source ripple_source_inst (.clk(clk), .resetn(resetn), .fire(fire),
		.bp_ripple_raw(bp_ripple_raw));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	always @(posedge ripple_pulse_out) rises++;

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 check("rdata", exp, rdata & m);
	endtask : rd_chk

	task automatic ripple();
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask : ripple

	// Bounded wait for the next pulse start; a miss ends the run
	task automatic wait_pulse(input int n);
		int r0;
		r0 = rises;
		for (int i = 0; i < n && rises == r0; i++) @(posedge clk);
		if (rises == r0) begin
			num_errors++;
			$display("MISMATCH pulse_start expected rise seen none");
			wrap_up();
		end
	endtask : wait_pulse

	task automatic scen_reset();
		check("fault", 32'h1, 32'(fault_out_n));
		check("centre", 32'(PERIOD_INIT), 32'(bp_centre));
		for (int a = 0; a < 8; a++) rd_chk(4'(a), 32'h0, 32'hffff_ffff);
		wr_reg(4'h9, 32'hffff_ffff);
		rd_chk(4'h9, 32'h0, 32'hffff_ffff);
	endtask : scen_reset

	task automatic scen_scale();
		logic [31:0] cm[4] = '{32'h2, 32'h40, 32'h400, 32'h2000};
		logic [31:0] em[4] = '{32'h1800, 32'h3000, 32'h18000, 32'h30000};
		logic [31:0] gm[4] = '{32'h2, 32'h4, 32'h8, 32'h10};
		for (int s = 0; s < 4; s++) begin
			wr_reg(REG_MOTOR, {6'h0, 2'(s), 8'h05, 6'h0, 2'(s), 8'hff});
			wr_reg(REG_FILT, {22'h0, 2'(s), 8'h40});
			#1 check("cond", 32'hff * cm[s], 32'(conductance_eff));
			check("emf", 32'h5 * em[s], backemf_eff);
			check("gain", gm[s], 32'(bp_gain));
		end
		check("damping", 32'h40, 32'(bp_damping));
		check("vout_an", 32'h100, 32'(vout_est));
		wr_reg(REG_CTRL, 32'h0010);
		repeat (8) @(posedge clk);
		#1 check("vout_est", 32'h200, 32'(vout_est));
	endtask : scen_scale

	// Three ripples against a threshold of two, with one extra in the blank
	task automatic scen_count();
		wr_reg(REG_THR, 32'h0001);
		wr_reg(REG_CTRL, 32'h0009);
		rd_chk(REG_CTRL, 32'h0009, 32'hffff_ffff);
		for (int i = 1; i < 4; i++) begin
			ripple();
			wait_pulse(20);
			if (i == 1) begin
				repeat (200) @(posedge clk);
				ripple();
			end
			repeat (2010) @(posedge clk);
			check("pulse_low", 32'h0, 32'(ripple_pulse_out));
			rd_chk(REG_COUNT, 32'(i), 32'hffff_ffff);
			check("lowpass", 32'(i), 32'(count_lowpass));
			if (i < 3) rd_chk(REG_STATUS, 32'h0, 32'h1);
			repeat (1970) @(posedge clk);
		end
		rd_chk(REG_STATUS, 32'h1, 32'h1);
		check("fault", 32'h0, 32'(fault_out_n));
		wr_reg(REG_CTRL, 32'h000b);
		rd_chk(REG_STATUS, 32'h0, 32'h1);
	endtask : scen_count

	task automatic scen_gate();
		logic [31:0] md[2] = '{32'h0000, 32'h0021};
		int r0;
		for (int k = 0; k < 2; k++) begin
			wr_reg(REG_CTRL, md[k]);
			repeat (2010) @(posedge clk);
			r0 = rises;
			ripple();
			repeat (3000) @(posedge clk);
			check("pulses", 32'(r0), 32'(rises));
			rd_chk(REG_COUNT, 32'h0, 32'hffff_ffff);
		end
	endtask : scen_gate

	// Inserted pulses go on, then mute after twelve with pulse disable
	task automatic scen_mute();
		int r0;
		wr_reg(REG_CTRL, 32'h0001);
		wait_pulse(6000);
		repeat (2100) @(posedge clk);
		wr_reg(REG_CTRL, 32'h0041);
		ripple();
		wait_pulse(20);
		r0 = rises;
		repeat (64000) @(posedge clk);
		check("inserted", 32'(r0 + 12), 32'(rises));
	endtask : scen_mute

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		resetn = 1'b0;
		fire = 1'b0;
		bus_req = '0;
		vout_diff = 12'h100;
		pwm_duty = 8'h80;
		vm_sample = 12'h400;
		num_errors = 0;
		num_checks = 0;
		rises = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		scen_reset();
		scen_scale();
		scen_count();
		scen_gate();
		scen_mute();
		wrap_up();
	end
endmodule : tb_top

bind ripple_count_param_logic ripple_checker ripple_checker_inst (
	.clk(clk), .resetn(resetn), .bus_req(bus_req), .bp_gain(bp_gain),
	.bp_damping(bp_damping), .conductance_eff(conductance_eff), .backemf_eff(backemf_eff),
	.ripple_pulse_out(ripple_pulse_out), .fault_out_n(fault_out_n));
